// ---- verilog/spll_cfg.sv ----
// Configuration and status logic for the system analog multiplier PLL.
// Assumes a memory-like nonvolatile source port answering one cycle after a request.
//
// Notes on behaviour
// (R1) Frequencies held as 48-bit numerator over 16-bit denominator.
// (R2) A control bit selects crystal directly or through the doubler.
// (R3) Feedback divider accepts 108 through 556; software keeps PLL in range.
// (R4) Reset loads PLL control fields from a nonvolatile source before operation.
// (R5) Source is OTP or EEPROM, whichever is enabled and valid.
// (R6) After loading, host writes to control fields are accepted anytime.
// (R7) Lock limits derive internally from configuration, no user register.
// (R8) Loss-of-lock alarm readable in status, optionally routed to a GPIO.
// (R9) Lock status tracks detector within cycles, reads unlocked while loading.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module spll_cfg (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic otp_enabled,
    input wire logic otp_valid,
    input wire logic eeprom_enabled,
    input wire logic eeprom_valid,
    output logic nv_req,
    output logic nv_sel_eeprom,
    output logic [1:0] nv_word,
    input wire logic [31:0] nv_data,
    input wire logic [9:0] ctrl_voltage,
    output logic pll_doubler_en,
    output logic [9:0] pll_fb_div,
    output logic cfg_busy,
    output logic gpio_lol,
    output logic irq
);
    // ********************************
    // Configuration load sequencer
    // ********************************
    typedef enum logic [1:0] {ST_PICK, ST_READ, ST_WAIT, ST_RUN} spll_ld_t;
    spll_ld_t state_ff;
    spll_pkg::spll_src_t src_ff;
    logic [1:0] word_ff;
    logic load_done_pulse;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_PICK;
            src_ff <= spll_pkg::SRC_NONE;
            word_ff <= 2'h0;
        end else begin
            unique case (state_ff)
                ST_PICK: begin
                    word_ff <= 2'h0;
                    if (otp_enabled && otp_valid) begin // R5
                        src_ff <= spll_pkg::SRC_OTP;
                        state_ff <= ST_READ;
                    end else if (eeprom_enabled && eeprom_valid) begin // R5
                        src_ff <= spll_pkg::SRC_EEPROM;
                        state_ff <= ST_READ;
                    end else begin
                        // No usable source: keep reset defaults and go operational.
                        state_ff <= ST_RUN;
                    end
                end
                ST_READ: state_ff <= ST_WAIT;
                ST_WAIT: begin
                    if (word_ff == 2'(spll_pkg::LOAD_WORDS - 1)) begin
                        state_ff <= ST_RUN;
                    end else begin
                        word_ff <= word_ff + 2'h1;
                        state_ff <= ST_READ;
                    end
                end
                ST_RUN: state_ff <= ST_RUN;
            endcase
        end
    end

    assign nv_req = (state_ff == ST_READ);
    assign nv_sel_eeprom = (src_ff == spll_pkg::SRC_EEPROM);
    assign nv_word = word_ff;
    assign cfg_busy = (state_ff != ST_RUN);
    assign load_done_pulse = (state_ff == ST_WAIT) &&
        (word_ff == 2'(spll_pkg::LOAD_WORDS - 1));

    // ********************************
    // PLL control fields
    // ********************************
    logic dbl_ff;
    logic gpio_en_ff;
    logic [9:0] fbdiv_ff;
    logic [47:0] freq_m_ff;
    logic [15:0] freq_n_ff;
    logic host_wr;
    logic [9:0] wr_fbdiv;
    logic [9:0] ld_fbdiv;
    logic fbdiv_ok;
    logic ld_fbdiv_ok;

    assign host_wr = reg_wr && (state_ff == ST_RUN); // R6
    assign wr_fbdiv = reg_wdata[spll_pkg::CTRL_FBDIV_LSB +: spll_pkg::FBDIV_W];
    assign ld_fbdiv = nv_data[spll_pkg::CTRL_FBDIV_LSB +: spll_pkg::FBDIV_W];
    assign fbdiv_ok = (wr_fbdiv >= spll_pkg::FBDIV_MIN) && (wr_fbdiv <= spll_pkg::FBDIV_MAX);
    assign ld_fbdiv_ok = (ld_fbdiv >= spll_pkg::FBDIV_MIN) && (ld_fbdiv <= spll_pkg::FBDIV_MAX);

    always_ff @(posedge clk) begin
        if (rst) begin
            dbl_ff <= 1'b0;
            gpio_en_ff <= 1'b0;
            fbdiv_ff <= spll_pkg::FBDIV_RST;
        end else if (state_ff == ST_WAIT && word_ff == 2'h0) begin
            dbl_ff <= nv_data[spll_pkg::CTRL_DBL_BIT]; // R4
            gpio_en_ff <= nv_data[spll_pkg::CTRL_GPIO_BIT];
            // An out-of-range divider would leave the loop unable to lock, so it is dropped.
            if (ld_fbdiv_ok) begin
                fbdiv_ff <= ld_fbdiv; // R3
            end
        end else if (host_wr && reg_addr == spll_pkg::ADDR_CTRL) begin
            dbl_ff <= reg_wdata[spll_pkg::CTRL_DBL_BIT]; // R2
            gpio_en_ff <= reg_wdata[spll_pkg::CTRL_GPIO_BIT];
            if (fbdiv_ok) begin
                fbdiv_ff <= wr_fbdiv; // R3
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            freq_m_ff <= spll_pkg::FREQ_M_RST;
            freq_n_ff <= spll_pkg::FREQ_N_RST;
        end else if (state_ff == ST_WAIT) begin
            if (word_ff == 2'h1) begin
                freq_m_ff[31:0] <= nv_data; // R1
            end else if (word_ff == 2'h2) begin
                freq_m_ff[47:32] <= nv_data[15:0];
            end else if (word_ff == 2'h3) begin
                freq_n_ff <= nv_data[15:0];
            end
        end else if (host_wr) begin
            if (reg_addr == spll_pkg::ADDR_FREQ_M_LO) begin
                freq_m_ff[31:0] <= reg_wdata; // R1
            end else if (reg_addr == spll_pkg::ADDR_FREQ_M_HI) begin
                freq_m_ff[47:32] <= reg_wdata[15:0];
            end else if (reg_addr == spll_pkg::ADDR_FREQ_N) begin
                freq_n_ff <= reg_wdata[15:0];
            end
        end
    end

    assign pll_doubler_en = dbl_ff;
    assign pll_fb_div = fbdiv_ff;

    // ********************************
    // Lock detection
    // ********************************
    // Window centre follows the divider setting; doubling lowers only the upper limit, by 4, half a margin step.
    logic [9:0] lim_lo_ff;
    logic [9:0] lim_hi_ff;
    logic [9:0] cv_s1_ff;
    logic [9:0] cv_s2_ff;
    logic [9:0] cv_s3_ff;
    logic [9:0] cv_ff;
    logic in_win;
    logic locked_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            lim_lo_ff <= 10'h000;
            lim_hi_ff <= 10'h000;
        end else begin
            lim_lo_ff <= (fbdiv_ff >> 1) - 10'(spll_pkg::LOCK_MARGIN); // R7
            lim_hi_ff <= (fbdiv_ff >> 1) + 10'(spll_pkg::LOCK_MARGIN) -
                (dbl_ff ? 10'h004 : 10'h000); // R7
        end
    end

    // The control voltage is a whole word from the analog side, so its bits may settle apart.
    // A value is taken only once the second and third stages agree; this costs a cycle of
    // lock latency but never compares a half-changed word against the window.
    always_ff @(posedge clk) begin
        if (rst) begin
            cv_s1_ff <= 10'h000;
            cv_s2_ff <= 10'h000;
            cv_s3_ff <= 10'h000;
        end else begin
            cv_s1_ff <= ctrl_voltage;
            cv_s2_ff <= cv_s1_ff;
            cv_s3_ff <= cv_s2_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cv_ff <= 10'h000;
        end else if (cv_s2_ff == cv_s3_ff) begin
            cv_ff <= cv_s3_ff;
        end
    end

    assign in_win = (cv_ff >= lim_lo_ff) && (cv_ff <= lim_hi_ff);

    always_ff @(posedge clk) begin
        if (rst) begin
            locked_ff <= 1'b0;
        end else begin
            locked_ff <= in_win && (state_ff == ST_RUN); // R9
        end
    end

    assign gpio_lol = gpio_en_ff && !locked_ff && (state_ff == ST_RUN); // R8

    // ********************************
    // Interrupts
    // ********************************
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    logic [1:0] irq_evt;

    assign irq_evt[spll_pkg::IRQ_LOL_BIT] = (state_ff == ST_RUN) && !in_win && locked_ff;
    assign irq_evt[spll_pkg::IRQ_LOAD_BIT] = load_done_pulse;

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_ff <= 2'h0;
        end else if (reg_wr && reg_addr == spll_pkg::ADDR_IRQ_STAT) begin
            irq_stat_ff <= (irq_stat_ff & ~reg_wdata[1:0]) | irq_evt;
        end else begin
            irq_stat_ff <= irq_stat_ff | irq_evt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_ff <= 2'h0;
        end else if (reg_wr && reg_addr == spll_pkg::ADDR_IRQ_MASK) begin
            irq_mask_ff <= reg_wdata[1:0];
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // ********************************
    // Register read port
    // ********************************
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                spll_pkg::ADDR_CTRL: reg_rdata <= {6'h00, fbdiv_ff, 14'h0000,
                    gpio_en_ff, dbl_ff};
                spll_pkg::ADDR_FREQ_M_LO: reg_rdata <= freq_m_ff[31:0];
                spll_pkg::ADDR_FREQ_M_HI: reg_rdata <= {16'h0000, freq_m_ff[47:32]};
                spll_pkg::ADDR_FREQ_N: reg_rdata <= {16'h0000, freq_n_ff};
                spll_pkg::ADDR_STATUS: reg_rdata <= {29'h0000_0000, cfg_busy,
                    !locked_ff, locked_ff}; // R8
                spll_pkg::ADDR_IRQ_STAT: reg_rdata <= {30'h0000_0000, irq_stat_ff};
                spll_pkg::ADDR_IRQ_MASK: reg_rdata <= {30'h0000_0000, irq_mask_ff};
                spll_pkg::ADDR_LOCK_LIM: reg_rdata <= {6'h00, lim_hi_ff, 6'h00, lim_lo_ff};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ********************************
    // Assertions
    // ********************************
    a_fbdiv_range: assert property (@(posedge clk) disable iff (rst) // R3
        fbdiv_ff >= spll_pkg::FBDIV_MIN && fbdiv_ff <= spll_pkg::FBDIV_MAX)
        else $error("Feedback divider out of range.");
    a_unlocked_loading: assert property (@(posedge clk) disable iff (rst) // R9
        cfg_busy |-> !locked_ff)
        else $error("Lock shown during load.");
    a_lock_tracks: assert property (@(posedge clk) disable iff (rst) // R9
        (state_ff == ST_RUN && in_win) |=> locked_ff)
        else $error("Lock status failed to follow detector.");
    a_volt_filter: assert property (@(posedge clk) disable iff (rst) // R9
        (cv_s2_ff != cv_s3_ff) |=> $stable(cv_ff))
        else $error("Control voltage taken before it settled.");
    a_host_blocked: assert property (@(posedge clk) disable iff (rst) // R6
        (cfg_busy && state_ff != ST_WAIT) |=> $stable(dbl_ff))
        else $error("Control changed while loading.");
    a_host_write: assert property (@(posedge clk) disable iff (rst) // R2
        (host_wr && reg_addr == spll_pkg::ADDR_CTRL) |=>
        dbl_ff == $past(reg_wdata[spll_pkg::CTRL_DBL_BIT]))
        else $error("Doubler select not written.");
    a_load_ends: assert property (@(posedge clk) disable iff (rst) // R4
        (state_ff == ST_READ && word_ff == 2'h0) |-> ##[1:8] !cfg_busy)
        else $error("Load did not finish.");
    a_src_choice: assert property (@(posedge clk) disable iff (rst) // R5
        (state_ff == ST_PICK && otp_enabled && otp_valid) |=>
        src_ff == spll_pkg::SRC_OTP)
        else $error("Wrong load source.");
    a_gpio_alarm: assert property (@(posedge clk) disable iff (rst) // R8
        (gpio_en_ff && !cfg_busy && !locked_ff) |-> gpio_lol)
        else $error("Alarm not routed to GPIO.");
    a_limits_follow: assert property (@(posedge clk) disable iff (rst) // R7
        $changed(fbdiv_ff) |=> lim_lo_ff == (fbdiv_ff >> 1) - 10'(spll_pkg::LOCK_MARGIN))
        else $error("Lock limits not derived.");
    a_freq_n_write: assert property (@(posedge clk) disable iff (rst) // R1
        (host_wr && reg_addr == spll_pkg::ADDR_FREQ_N) |=>
        freq_n_ff == $past(reg_wdata[15:0]))
        else $error("Denominator not written.");
    c_load_otp: cover property (@(posedge clk) src_ff == spll_pkg::SRC_OTP && !cfg_busy);
    c_load_eeprom: cover property (@(posedge clk) src_ff == spll_pkg::SRC_EEPROM && !cfg_busy);
    c_lock_lost: cover property (@(posedge clk) irq_evt[spll_pkg::IRQ_LOL_BIT]);
    c_irq: cover property (@(posedge clk) irq);
endmodule // spll_cfg
`default_nettype wire

// ---- shared/spll_pkg.sv ----
// Constants for the system PLL configuration and status block.
// Assumes a single 100 MHz clock domain and a plain register port.
package spll_pkg;
    // ********************************
    // Register offsets
    // ********************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FREQ_M_LO = 8'h04;
    localparam logic [7:0] ADDR_FREQ_M_HI = 8'h08;
    localparam logic [7:0] ADDR_FREQ_N = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_LOCK_LIM = 8'h1C;
    // ********************************
    // Field positions and limits
    // ********************************
    localparam int CTRL_DBL_BIT = 0;
    localparam int CTRL_GPIO_BIT = 1;
    localparam int CTRL_FBDIV_LSB = 16;
    localparam int FBDIV_W = 10;
    localparam logic [9:0] FBDIV_MIN = 10'h06C;
    localparam logic [9:0] FBDIV_MAX = 10'h22C;
    localparam int IRQ_LOL_BIT = 0;
    localparam int IRQ_LOAD_BIT = 1;
    localparam int M_W = 48;
    localparam int N_W = 16;
    // ********************************
    // Reset values and load timing
    // ********************************
    localparam logic [9:0] FBDIV_RST = 10'h06C;
    localparam logic [47:0] FREQ_M_RST = 48'h0000_0000_0000;
    localparam logic [15:0] FREQ_N_RST = 16'h0001;
    localparam int LOAD_WORDS = 4;
    localparam int LOCK_MARGIN = 8;
    typedef enum logic [1:0] {SRC_NONE, SRC_OTP, SRC_EEPROM} spll_src_t;
endpackage

// ---- tb/spll_nv_model.sv ----
// Behavioural nonvolatile configuration source: one-time-programmable image and serial EEPROM.
// Assumes one request pulse per word, answered in the cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module spll_nv_model #(
    parameter logic [127:0] OTP_IMG = 128'h0,
    parameter logic [127:0] EEP_IMG = 128'h0
) (
    input wire logic clk,
    input wire logic nv_req,
    input wire logic nv_sel_eeprom,
    input wire logic [1:0] nv_word,
    output logic [31:0] nv_data
);
    logic [31:0] data_q = 32'h5A5A_5A5A;
    assign nv_data = data_q;
    // Outside the answer cycle the data toggles, so a late sample never looks valid.
    always @(posedge clk) begin
        if (nv_req) begin
            data_q <= nv_sel_eeprom ? EEP_IMG[{nv_word, 5'h00} +: 32] :
                OTP_IMG[{nv_word, 5'h00} +: 32];
        end else begin
            data_q <= ~data_q;
        end
    end
endmodule // spll_nv_model
`default_nettype wire

// ---- tb/spll_cfg_tb_top.sv ----
// Self-checking testbench for the system PLL configuration and status block.
// Assumes the nonvolatile source model and a 100 MHz clock with synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module spll_cfg_tb_top;
    localparam logic [127:0] OTP_IMG = {32'h0000_009E, 32'h0000_ABCD,
        32'h1234_5678, 32'h012C_0001};
    localparam logic [127:0] EEP_IMG = {32'h0000_0007, 32'h0000_0001,
        32'h0000_0002, 32'h00C8_0000};
    localparam logic [31:0] CTRL_SEQ [4] = '{32'h006C_0000, 32'h022C_0001,
        32'h006B_0000, 32'h022D_0001};
    localparam logic [9:0] FB_EXP [4] = '{10'h06C, 10'h22C, 10'h22C, 10'h22C};
    logic clk, rst, reg_wr, reg_rd, nv_req, nv_sel_eeprom, pll_doubler_en, cfg_busy, gpio_lol, irq;
    logic otp_enabled, otp_valid, eeprom_enabled, eeprom_valid;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, nv_data;
    logic [1:0] nv_word;
    logic [9:0] ctrl_voltage, pll_fb_div;
    int mismatches, total_checks;

    spll_cfg u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_enabled(otp_enabled),
        .otp_valid(otp_valid), .eeprom_enabled(eeprom_enabled), .eeprom_valid(eeprom_valid),
        .nv_req(nv_req), .nv_sel_eeprom(nv_sel_eeprom), .nv_word(nv_word), .nv_data(nv_data),
        .ctrl_voltage(ctrl_voltage), .pll_doubler_en(pll_doubler_en), .pll_fb_div(pll_fb_div),
        .cfg_busy(cfg_busy), .gpio_lol(gpio_lol), .irq(irq));
    spll_nv_model #(.OTP_IMG(OTP_IMG), .EEP_IMG(EEP_IMG)) u_nv (.clk(clk), .nv_req(nv_req),
        .nv_sel_eeprom(nv_sel_eeprom), .nv_word(nv_word), .nv_data(nv_data));

    always #5 clk = ~clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task end_of_test;
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask

    // The lock detector sits behind a three-stage agreement filter, so give it a few edges.
    task settle;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task load_seq(input logic eep, input int nreq, input logic [31:0] w0);
        int k;
        int n;
        k = 0;
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        reg_addr <= spll_pkg::ADDR_STATUS;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("status while loading", reg_rdata & 32'h5, 32'h4);
        for (n = 0; n < 30 && cfg_busy !== 1'b0; n++) begin
            if (nv_req === 1'b1) begin
                chk("nv word", 32'(nv_word), k);
                chk("nv source", 32'(nv_sel_eeprom), 32'(eep));
                k++;
            end
            @(posedge clk);
            #1;
        end
        chk("nv requests", k, nreq);
        chk("busy after load", 32'(cfg_busy), 32'h0);
        if (cfg_busy !== 1'b0) end_of_test;
        chk("doubler", 32'(pll_doubler_en), 32'(w0[0]));
        chk("fb div", 32'(pll_fb_div), 32'(w0[25:16]));
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task test_otp_load;
        load_seq(1'b0, 4, OTP_IMG[31:0]);
        rd("freq m lo", spll_pkg::ADDR_FREQ_M_LO, OTP_IMG[63:32]);
        rd("freq m hi", spll_pkg::ADDR_FREQ_M_HI, OTP_IMG[95:64]);
        rd("freq n", spll_pkg::ADDR_FREQ_N, OTP_IMG[127:96]);
        rd("unmapped", 8'h20, 32'h0);
        rd("lock limits dbl", spll_pkg::ADDR_LOCK_LIM, 32'h009A_008E);
        rd("irq status", spll_pkg::ADDR_IRQ_STAT, 32'h2);
        chk("irq masked", 32'(irq), 32'h0);
        wr(spll_pkg::ADDR_IRQ_MASK, 32'h2);
        settle;
        chk("irq load done", 32'(irq), 32'h1);
        wr(spll_pkg::ADDR_IRQ_STAT, 32'h2);
        settle;
        chk("irq cleared", 32'(irq), 32'h0);
    endtask

    task test_fbdiv;
        for (int i = 0; i < 4; i++) begin
            wr(spll_pkg::ADDR_CTRL, CTRL_SEQ[i]);
            chk("fb div", 32'(pll_fb_div), 32'(FB_EXP[i]));
            chk("doubler", 32'(pll_doubler_en), 32'(CTRL_SEQ[i][0]));
        end
        wr(spll_pkg::ADDR_FREQ_M_LO, 32'h89AB_CDEF);
        wr(spll_pkg::ADDR_FREQ_M_HI, 32'hFFFF_0123);
        wr(spll_pkg::ADDR_FREQ_N, 32'h0001_00ED);
        rd("host m lo", spll_pkg::ADDR_FREQ_M_LO, 32'h89AB_CDEF);
        rd("host m hi", spll_pkg::ADDR_FREQ_M_HI, 32'h0000_0123);
        rd("host n", spll_pkg::ADDR_FREQ_N, 32'h0000_00ED);
    endtask

    task test_lock_alarm;
        wr(spll_pkg::ADDR_CTRL, 32'h012C_0002);
        rd("lock limits", spll_pkg::ADDR_LOCK_LIM, 32'h009E_008E);
        ctrl_voltage <= 10'h096;
        settle;
        rd("status locked", spll_pkg::ADDR_STATUS, 32'h1);
        chk("gpio locked", 32'(gpio_lol), 32'h0);
        wr(spll_pkg::ADDR_IRQ_STAT, 32'h3);
        rd("irq status locked", spll_pkg::ADDR_IRQ_STAT, 32'h0);
        wr(spll_pkg::ADDR_IRQ_MASK, 32'h1);
        ctrl_voltage <= 10'h000;
        settle;
        rd("status lost", spll_pkg::ADDR_STATUS, 32'h2);
        chk("gpio lost", 32'(gpio_lol), 32'h1);
        chk("irq lost", 32'(irq), 32'h1);
        rd("irq status lost", spll_pkg::ADDR_IRQ_STAT, 32'h1);
        wr(spll_pkg::ADDR_IRQ_MASK, 32'h0);
        settle;
        chk("irq masked off", 32'(irq), 32'h0);
        wr(spll_pkg::ADDR_IRQ_MASK, 32'h1);
        wr(spll_pkg::ADDR_IRQ_STAT, 32'h1);
        settle;
        chk("irq after clear", 32'(irq), 32'h0);
        wr(spll_pkg::ADDR_CTRL, 32'h012C_0000);
        chk("gpio unrouted", 32'(gpio_lol), 32'h0);
        ctrl_voltage <= 10'h096;
    endtask

    task test_other_sources;
        otp_valid <= 1'b0;
        load_seq(1'b1, 4, EEP_IMG[31:0]);
        rd("eeprom freq n", spll_pkg::ADDR_FREQ_N, EEP_IMG[127:96]);
        eeprom_enabled <= 1'b0;
        load_seq(1'b0, 0, 32'h006C_0000);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        otp_enabled = 1'b1;
        otp_valid = 1'b1;
        eeprom_enabled = 1'b1;
        eeprom_valid = 1'b1;
        ctrl_voltage = 10'h096;
        mismatches = 0;
        total_checks = 0;
        test_otp_load;
        test_fbdiv;
        test_lock_alarm;
        test_other_sources;
        end_of_test;
    end
endmodule // spll_cfg_tb_top
`default_nettype wire
